// ---- hw/tpe_pkg.sv ----
package tpe_pkg;
    // register map (byte addresses, word aligned)
    localparam logic [3:0]  TPE_ADDR_CTRL      = 4'h0;  // channel polarity/enable control
    localparam logic [3:0]  TPE_ADDR_PROTECTION_LEVEL      = 4'h4;  // protection level mirror
    localparam logic [3:0]  TPE_ADDR_STATUS    = 4'h8;  // live channel state
    localparam int          TPE_ADDR_W         = 4;
    localparam int          TPE_DATA_W         = 32;
    localparam int          TPE_NUM_CH         = 3;
    localparam int          TPE_BITS_PER_CH    = 4;
    // field positions within one channel nibble
    localparam int          TPE_F_EN           = 0;
    localparam int          TPE_F_P            = 1;
    localparam int          TPE_F_NEN          = 2;
    localparam int          TPE_F_NP           = 3;
    localparam int          TPE_CTRL_W         = 12;
    localparam logic [11:0] TPE_CTRL_RESET     = 12'h000;
    // polarity field mask: main and complementary polarity of all channels
    localparam logic [11:0] TPE_POL_MASK       = 12'haaa;
    localparam logic [1:0]  TPE_PROTECTION_LEVEL_RESET     = 2'h0;
    localparam logic [1:0]  TPE_PROTECTION_LEVEL_LVL3      = 2'h3;
    localparam logic [1:0]  TPE_PROTECTION_LEVEL_LVL2      = 2'h2;
    localparam logic [31:0] TPE_UNMAPPED_DATA  = 32'h0000_0000;
    // input edge selection codes {comp_polarity, main_polarity}
    typedef enum logic [1:0] {
        TPE_EDGE_RISE = 2'h0,
        TPE_EDGE_FALL = 2'h1,
        TPE_EDGE_RSVD = 2'h2,
        TPE_EDGE_BOTH = 2'h3
    } tpe_edge_e;
endpackage : tpe_pkg

// ---- hw/tpe_channel.sv ----
`timescale 1ns/1ps
module tpe_channel
    import tpe_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // channel control bits
    input  wire logic channel_enable_i,
    input  wire logic main_polarity_i,
    input  wire logic comp_out_enable_i,
    input  wire logic comp_polarity_i,
    input  wire logic input_mode_i,
    // compare reference signals and filtered input
    input  wire logic main_ref_i,
    input  wire logic comp_ref_i,
    input  wire logic filtered_input_i,
    // outputs
    output logic      main_output_o,
    output logic      main_output_en_o,
    output logic      comp_output_o,
    output logic      comp_output_en_o,
    output logic      selected_input_o,
    output logic      capture_event_o
);
    logic  prev_q;
    logic  main_out_q;
    logic  main_en_q;
    logic  comp_out_q;
    logic  comp_en_q;
    logic  sel_q;
    logic  cap_q;
    wire   rise_w;
    wire   fall_w;
    wire   edge_hit_w;
    wire   out_mode_w;
    logic  edge_hit_w_c;
    tpe_edge_e edge_sel_w;

    // edge detection and edge selection
    assign edge_sel_w = tpe_edge_e'({comp_polarity_i, main_polarity_i});
    assign rise_w     = filtered_input_i & ~prev_q;
    assign fall_w     = ~filtered_input_i & prev_q;
    assign out_mode_w = ~input_mode_i;

    always_comb begin
        case (edge_sel_w)
            TPE_EDGE_RISE: edge_hit_w_c = rise_w;
            TPE_EDGE_FALL: edge_hit_w_c = fall_w;
            TPE_EDGE_BOTH: edge_hit_w_c = rise_w | fall_w;
            default:       edge_hit_w_c = 1'b0;  // reserved code gives no events
        endcase
    end
    assign edge_hit_w = edge_hit_w_c;

    // registered outputs
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            prev_q     <= 1'b0;
            main_out_q <= 1'b0;
            main_en_q  <= 1'b0;
            comp_out_q <= 1'b0;
            comp_en_q  <= 1'b0;
            sel_q      <= 1'b0;
            cap_q      <= 1'b0;
        end else begin
            prev_q     <= filtered_input_i;
            main_out_q <= main_ref_i ^ main_polarity_i;
            main_en_q  <= out_mode_w & channel_enable_i;
            comp_out_q <= comp_ref_i ^ comp_polarity_i;
            comp_en_q  <= out_mode_w & comp_out_enable_i;
            sel_q      <= filtered_input_i ^ (main_polarity_i & ~comp_polarity_i);
            cap_q      <= input_mode_i & channel_enable_i & edge_hit_w;
        end
    end

    assign main_output_o    = main_out_q;
    assign main_output_en_o = main_en_q;
    assign comp_output_o    = comp_out_q;
    assign comp_output_en_o = comp_en_q;
    assign selected_input_o = sel_q;
    assign capture_event_o  = cap_q;
endmodule : tpe_channel

// ---- hw/tpe_top.sv ----
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
// Operation
// - in output mode the main output is active high with main polarity 0 and active low with 1.
// - in output mode the complementary output is active high with its polarity 0, low with 1.
// - the complementary output is enabled only while its enable bit is 1.
// - in input mode the pair {comp polarity, main polarity} picks the active edge.
// - pair 00 selects the rising edge and passes the filtered input uninverted.
// - pair 01 selects the falling edge and passes the filtered input inverted.
// - pair 11 selects both edges uninverted; pair 10 is reserved and software avoids it.
// - polarity bit writes are ignored while the protection level is 11 or 10.
// - channels 1 and 2 behave as channel 0, using bits 7..4 and 11..8.
// - channel 0 uses bit 3 comp polarity, bit 2 comp enable, bit 1 main polarity.
// - the channel enable bit enables the main output or capture events; 0 disables.
module tpe_top
    import tpe_pkg::*;
#(
    parameter int NUM_CH = TPE_NUM_CH
)(
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  resetn_i,
    // avalon-mm slave
    input  wire logic [TPE_ADDR_W-1:0] avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [TPE_DATA_W-1:0] avs_writedata_i,
    input  wire logic [3:0]            avs_byteenable_i,
    output logic      [TPE_DATA_W-1:0] avs_readdata_o,
    output logic                       avs_waitrequest_o,
    output logic      [1:0]            avs_response_o,
    // protection level from the protect register
    input  wire logic [1:0]            protection_level_i,
    // per channel mode and signals
    input  wire logic [NUM_CH-1:0]     input_mode_i,
    input  wire logic [NUM_CH-1:0]     main_ref_i,
    input  wire logic [NUM_CH-1:0]     comp_ref_i,
    input  wire logic [NUM_CH-1:0]     filtered_input_i,
    output logic      [NUM_CH-1:0]     main_output_o,
    output logic      [NUM_CH-1:0]     main_output_en_o,
    output logic      [NUM_CH-1:0]     comp_output_o,
    output logic      [NUM_CH-1:0]     comp_output_en_o,
    output logic      [NUM_CH-1:0]     selected_filtered_input_o,
    output logic      [NUM_CH-1:0]     capture_event_o
);
    // bus state machine
    typedef enum logic [1:0] {
        TPE_ST_IDLE = 2'b01,
        TPE_ST_ACK  = 2'b10
    } tpe_state_e;

    tpe_state_e                    state_q;
    tpe_state_e                    state_d;
    logic      [TPE_CTRL_W-1:0]    ctrl_q;
    logic      [TPE_CTRL_W-1:0]    ctrl_d;
    logic      [TPE_DATA_W-1:0]    rdata_q;
    logic      [TPE_DATA_W-1:0]    rdata_d;
    logic      [1:0]               resp_q;
    logic      [1:0]               resp_d;
    wire                           req_w;
    wire                           hit_ctrl_w;
    wire                           hit_protection_level_w;
    wire                           hit_stat_w;
    wire                           mapped_w;
    wire                           locked_w;
    wire       [TPE_CTRL_W-1:0]    wmask_w;
    wire       [TPE_CTRL_W-1:0]    merged_w;
    wire       [TPE_DATA_W-1:0]    status_w;

    // byte lane mask for the low 12 bits
    function automatic logic [TPE_CTRL_W-1:0] lane_mask(input logic [3:0] be);
        lane_mask = {{4{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    // address decode
    assign req_w      = (avs_read_i | avs_write_i) & (state_q == TPE_ST_IDLE);
    assign hit_ctrl_w = (avs_address_i == TPE_ADDR_CTRL);
    assign hit_protection_level_w = (avs_address_i == TPE_ADDR_PROTECTION_LEVEL);
    assign hit_stat_w = (avs_address_i == TPE_ADDR_STATUS);
    assign mapped_w   = hit_ctrl_w | hit_protection_level_w | hit_stat_w;

    // write merge with protection lock on polarity bits
    assign locked_w = (protection_level_i == TPE_PROTECTION_LEVEL_LVL3) |
                      (protection_level_i == TPE_PROTECTION_LEVEL_LVL2);
    assign wmask_w  = lane_mask(avs_byteenable_i) &
                      ~(locked_w ? TPE_POL_MASK : TPE_CTRL_RESET);
    assign merged_w = (ctrl_q & ~wmask_w) | (avs_writedata_i[TPE_CTRL_W-1:0] & wmask_w);

    // live state: capture events, enables, selected inputs
    assign status_w = {{(TPE_DATA_W-4*NUM_CH){1'b0}}, capture_event_o,
                       selected_filtered_input_o, comp_output_en_o, main_output_en_o};

    // next state of the slave
    always_comb begin
        state_d = state_q;
        ctrl_d  = ctrl_q;
        rdata_d = rdata_q;
        resp_d  = resp_q;
        case (state_q)
            TPE_ST_IDLE: begin
                if (req_w) begin
                    state_d = TPE_ST_ACK;
                    resp_d  = mapped_w ? 2'h0 : 2'h2;
                    if (avs_write_i && hit_ctrl_w) begin
                        ctrl_d = merged_w;
                    end
                    if (hit_ctrl_w) begin
                        rdata_d = {{(TPE_DATA_W-TPE_CTRL_W){1'b0}}, ctrl_q};
                    end else if (hit_protection_level_w) begin
                        rdata_d = {{(TPE_DATA_W-2){1'b0}}, protection_level_i};
                    end else if (hit_stat_w) begin
                        rdata_d = status_w;
                    end else begin
                        rdata_d = TPE_UNMAPPED_DATA;
                    end
                end
            end
            TPE_ST_ACK: state_d = TPE_ST_IDLE;
            default:    state_d = TPE_ST_IDLE;
        endcase
    end

    // slave registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_q <= TPE_ST_IDLE;
            ctrl_q  <= TPE_CTRL_RESET;
            rdata_q <= TPE_UNMAPPED_DATA;
            resp_q  <= 2'h0;
        end else begin
            state_q <= state_d;
            ctrl_q  <= ctrl_d;
            rdata_q <= rdata_d;
            resp_q  <= resp_d;
        end
    end

    // waitrequest drops in the acknowledge cycle
    assign avs_waitrequest_o = (state_q != TPE_ST_ACK);
    assign avs_readdata_o    = rdata_q;
    assign avs_response_o    = resp_q;

    // one channel per nibble
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            tpe_channel u_ch (
                .clk_i            (clk_i),
                .resetn_i         (resetn_i),
                .channel_enable_i (ctrl_q[g*TPE_BITS_PER_CH+TPE_F_EN]),
                .main_polarity_i  (ctrl_q[g*TPE_BITS_PER_CH+TPE_F_P]),
                .comp_out_enable_i(ctrl_q[g*TPE_BITS_PER_CH+TPE_F_NEN]),
                .comp_polarity_i  (ctrl_q[g*TPE_BITS_PER_CH+TPE_F_NP]),
                .input_mode_i     (input_mode_i[g]),
                .main_ref_i       (main_ref_i[g]),
                .comp_ref_i       (comp_ref_i[g]),
                .filtered_input_i (filtered_input_i[g]),
                .main_output_o    (main_output_o[g]),
                .main_output_en_o (main_output_en_o[g]),
                .comp_output_o    (comp_output_o[g]),
                .comp_output_en_o (comp_output_en_o[g]),
                .selected_input_o (selected_filtered_input_o[g]),
                .capture_event_o  (capture_event_o[g])
            );
        end
    endgenerate
endmodule : tpe_top

// ---- tb/tpe_top_properties.sv ----
`timescale 1ns/1ps
module tpe_top_properties
    import tpe_pkg::*;
#(
    parameter int NUM_CH = TPE_NUM_CH
)(
    // clock, reset and bus
    input wire logic                  clk_i,
    input wire logic                  resetn_i,
    input wire logic [TPE_ADDR_W-1:0] avs_address_i,
    input wire logic                  avs_read_i,
    input wire logic                  avs_write_i,
    input wire logic [TPE_DATA_W-1:0] avs_readdata_o,
    input wire logic                  avs_waitrequest_o,
    input wire logic [1:0]            avs_response_o,
    // channel signals
    input wire logic [NUM_CH-1:0]     input_mode_i,
    input wire logic [NUM_CH-1:0]     main_ref_i,
    input wire logic [NUM_CH-1:0]     comp_ref_i,
    input wire logic [NUM_CH-1:0]     main_output_o,
    input wire logic [NUM_CH-1:0]     main_output_en_o,
    input wire logic [NUM_CH-1:0]     comp_output_o,
    input wire logic [NUM_CH-1:0]     comp_output_en_o,
    input wire logic [NUM_CH-1:0]     capture_event_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // a write completes here, so polarity may move
    wire wr_ack = avs_write_i && !avs_waitrequest_o;
    // bus handshake and decode
    a_wait_ack: assert property ($rose(avs_read_i || avs_write_i) |->
        avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("ack not one wait state");
    a_wait_idle: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
        else $error("ack without request");
    a_resp_unmapped: assert property (!avs_waitrequest_o && avs_read_i && avs_address_i > 4'h8
        |-> avs_response_o == 2'h2 && avs_readdata_o == '0) else $error("unmapped read");
    a_read_upper: assert property (
        !avs_waitrequest_o && avs_read_i && avs_address_i == TPE_ADDR_CTRL
        |-> avs_readdata_o[31:12] == '0 && avs_response_o == 2'h0) else $error("ctrl read");
    // outputs follow their reference while polarity is steady
    a_main_follow: assert property ($past(resetn_i) && !wr_ack && !$past(wr_ack) |=>
        (main_output_o ^ $past(main_output_o)) == ($past(main_ref_i) ^ $past(main_ref_i, 2)))
        else $error("main output lost its reference");
    a_comp_follow: assert property ($past(resetn_i) && !wr_ack && !$past(wr_ack) |=>
        (comp_output_o ^ $past(comp_output_o)) == ($past(comp_ref_i) ^ $past(comp_ref_i, 2)))
        else $error("comp output lost its reference");
    a_oen_mode: assert property ($past(resetn_i) |->
        ((main_output_en_o | comp_output_en_o) & $past(input_mode_i)) == '0)
        else $error("output enabled in input mode");
    a_capture_mode: assert property ($past(resetn_i) |->
        (capture_event_o & ~$past(input_mode_i)) == '0) else $error("capture in output mode");
endmodule : tpe_top_properties

bind tpe_top tpe_top_properties #(.NUM_CH(NUM_CH)) chk_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_response_o(avs_response_o), .input_mode_i(input_mode_i), .main_ref_i(main_ref_i),
    .comp_ref_i(comp_ref_i), .main_output_o(main_output_o), .comp_output_o(comp_output_o),
    .main_output_en_o(main_output_en_o), .comp_output_en_o(comp_output_en_o),
    .capture_event_o(capture_event_o));

// ---- tb/tpe_pin_model.sv ----
`timescale 1ns/1ps
module tpe_pin_model
    import tpe_pkg::*;
(
    // clock
    input  wire logic                  clk_i,
    // level put on the channel pins
    input  wire logic [TPE_NUM_CH-1:0] pin_level_i,
    // filtered input towards the timer
    output logic      [TPE_NUM_CH-1:0] filtered_o
);
    // two stages stand in for the input filter, so each pin step arrives clean
    logic [TPE_NUM_CH-1:0] sync_q;
    always_ff @(posedge clk_i) begin
        sync_q     <= pin_level_i;
        filtered_o <= sync_q;
    end
endmodule : tpe_pin_model

// ---- tb/tb_tpe_top.sv ----
`timescale 1ns/1ps
module tb_tpe_top
    import tpe_pkg::*;
;
    logic        clk_i, resetn_i, rd, wr, wt;
    logic [3:0]  adr;
    logic [31:0] wd, rdat, rdat_s, rnd, acc;
    logic [11:0] ctrl_m;
    logic [1:0]  rsp, protection_level, rsp_s;
    logic [2:0]  mode, mref, cref, pin, filt, mo, moe, co, coe, sel, cap, en;
    int          error_cnt, tests_run, n0;
    tpe_top #(.NUM_CH(3)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .avs_response_o(rsp),
        .protection_level_i(protection_level), .input_mode_i(mode), .main_ref_i(mref), .comp_ref_i(cref),
        .filtered_input_i(filt), .main_output_o(mo), .main_output_en_o(moe),
        .comp_output_o(co), .comp_output_en_o(coe), .selected_filtered_input_o(sel),
        .capture_event_o(cap));
    tpe_pin_model pin_u (.clk_i(clk_i), .pin_level_i(pin), .filtered_o(filt));
    // clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // control word after a write under a given protection level
    function automatic logic [11:0] exp_ctrl(input logic [11:0] o, d, input logic [1:0] p);
        return p[1] ? ((d & ~TPE_POL_MASK) | (o & TPE_POL_MASK)) : d;
    endfunction : exp_ctrl
    // one field bit gathered from all three channel nibbles
    function automatic logic [2:0] fld(input logic [11:0] c, input int k);
        return {c[8+k], c[4+k], c[k]};
    endfunction : fld
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        adr <= a;
        wd  <= d;
        wr  <= w;
        rd  <= !w;
        // sample waitrequest at each rising edge; answer taken at that same edge
        do begin
            @(posedge clk_i);
            n++;
        end while (wt !== 1'b0 && n < 40);
        if (n == 40) error_cnt++;
        rsp_s  = rsp;
        rdat_s = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (w && a == TPE_ADDR_CTRL) ctrl_m = exp_ctrl(ctrl_m, d[11:0], protection_level);
    endtask : bus
    task automatic report_and_stop();
        $display("mismatches %0d, checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // watchdog
    initial begin
        #(25 * 5000);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        {rd, wr, adr, wd, protection_level, mode, mref, cref, pin, ctrl_m} = '0;
        {error_cnt, tests_run} = '0;
        resetn_i = 1'b0;
        rnd = 32'he7e04500;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        bus(0, TPE_ADDR_CTRL, 0);
        chk(rdat_s, 0);
        // random control words under every protection level, output mode
        for (int i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            @(posedge clk_i);
            protection_level <= (i < 4) ? 2'(i) : rnd[13:12];
            mref <= rnd[16:14];
            cref <= rnd[19:17];
            bus(1, TPE_ADDR_CTRL, rnd);
            bus(0, TPE_ADDR_CTRL, 0);
            @(negedge clk_i);
            chk(rdat_s, {20'h0, ctrl_m});
            bus(0, TPE_ADDR_PROTECTION_LEVEL, 0);
            chk(rdat_s, {30'h0, protection_level});
            chk(mo, mref ^ fld(ctrl_m, 1));
            chk(co, cref ^ fld(ctrl_m, 3));
            chk({coe, moe}, {fld(ctrl_m, 2), fld(ctrl_m, 0)});
        end
        // unmapped place: write ignored, read zero with error response
        bus(1, 4'hc, 32'hfff);
        bus(0, 4'hc, 0);
        chk({rsp_s, rdat_s}, {2'h2, 32'h0});
        // input mode, each legal polarity pair, rising then falling pin
        @(posedge clk_i);
        protection_level <= 2'h0;
        mode <= 3'h7;
        for (int p = 0; p < 4; p++) begin
            if (p == 2) continue; // reserved pair never selected
            rnd = lfsr(rnd);
            en = {rnd[0], 2'b11};
            bus(1, TPE_ADDR_CTRL, {20'h0, {p[1], 1'b0, p[0], en[2]},
                {p[1], 1'b0, p[0], 1'b1}, {p[1], 1'b0, p[0], 1'b1}});
            repeat (4) @(posedge clk_i);
            for (int l = 1; l >= 0; l--) begin
                @(posedge clk_i);
                pin <= {3{l[0]}};
                acc = '0;
                n0 = 0;
                repeat (8) begin
                    @(negedge clk_i);
                    acc = acc | cap;
                    n0 += cap[0];
                end
                chk(acc, en & {3{(p == 3) || (l[0] == (p == 0))}});
                chk(n0, ((p == 3) || (l[0] == (p == 0))) ? 1 : 0);
                chk(sel, {3{l[0] ^ (p == 1)}});
                bus(0, TPE_ADDR_STATUS, 0);
                chk(rdat_s, {23'h0, {3{l[0] ^ (p == 1)}}, 6'h0});
            end
        end
        report_and_stop();
    end
endmodule : tb_tpe_top
